// file: common/swap_table_read_instr_pkg.sv
// Encodings, phases and reset values for the swap and table read unit.
`default_nettype none
package swap_table_read_pkg;
   localparam int PTR_W = 21;
   localparam logic [5:0] SWAP_OPC = 6'h0e;
   localparam logic [13:0] TRD_OPC = 14'h0002;
   localparam int SWAP_OPC_LSB = 10;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam int TRD_OPC_LSB = 2;
   localparam logic [1:0] UPD_NONE = 2'h0;
   localparam logic [1:0] UPD_POST_INC = 2'h1;
   localparam logic [1:0] UPD_POST_DEC = 2'h2;
   localparam logic [1:0] UPD_PRE_INC = 2'h3;
   localparam logic [20:0] PTR_RESET = 21'h00_0000;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [20:0] PTR_ONE = 21'h00_0001;
   typedef enum logic [1:0] {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b10,
      Q4 = 2'b11
   } phase_t;
endpackage
`default_nettype wire

// file: rtl/nibble_swap_table_read_exec.sv
// Decode and execute logic for the nibble swap and table read instructions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE1) Swap is bits 15:10 = 001110; bits 9 and 8 select dest and bank.
// (RULE2) Swap exchanges the two nibbles and touches no status flag.
// (RULE3) Dest bit 0 writes working register, 1 writes the data register.
// (RULE4) Bank bit 0 uses fast bank; bank bit 1 uses bank select register.
// (RULE5) Table read decoded from 0000 0000 0000 10 plus update code.
// (RULE6) Codes: 0 no change, 1 post-inc, 2 post-dec, 3 pre-inc.
// (RULE7) Table pointer is 21 bits and wraps on increment and decrement.
// (RULE8) Pointer bit 0 picks low byte (0) or high byte (1).
// (RULE9) Table read loads the chosen byte into table latch, flags unchanged.
// (RULE10) Table read takes two cycles: memory read Q2, latch write Q4.
// (RULE11) Swap is one cycle: read Q2, process Q3, write Q4.
module nibble_swap_table_read_exec
   import swap_table_read_pkg::*;
#(
   parameter int PTR_WIDTH = PTR_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [3:0] bank_select_register,
   input wire logic [7:0] working_register,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] pm_rdata,
   output logic busy,
   output logic [1:0] phase,
   output logic [11:0] reg_addr,
   output logic reg_rd,
   output logic reg_we,
   output logic [7:0] reg_wdata,
   output logic work_reg_we,
   output logic [7:0] work_reg_wdata,
   output logic [PTR_WIDTH-2:0] pm_addr,
   output logic pm_rd,
   output logic [PTR_WIDTH-1:0] table_pointer,
   output logic [7:0] table_latch,
   output logic status_we
);
   import swap_table_read_pkg::*;

   phase_t phase_ff;
   logic swap_ff, trd1_ff, trd2_ff;
   logic dest_ff, bank_ff;
   logic [7:0] faddr_ff, data_ff, swapped_ff;
   logic [1:0] upd_ff;
   logic [PTR_WIDTH-1:0] ptr_ff, rd_ptr_ff;
   logic [7:0] latch_ff;
   logic [7:0] pm_byte_ff;
   logic is_swap, is_trd;
   logic [PTR_WIDTH-1:0] one_p;

   assign one_p = PTR_WIDTH'(PTR_ONE);
   assign is_swap = instr_word[15:SWAP_OPC_LSB] == SWAP_OPC; // [RULE1]
   assign is_trd = instr_word[15:TRD_OPC_LSB] == TRD_OPC; // [RULE5]

   // Four phases per instruction cycle; decode happens only at Q1.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff <= Q1;
      end else begin
         phase_ff <= phase_t'(phase_ff + 2'h1);
      end
   end

   // Decode at the end of Q1.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         swap_ff <= 1'b0;
         trd1_ff <= 1'b0;
         trd2_ff <= 1'b0;
         dest_ff <= 1'b0;
         bank_ff <= 1'b0;
         faddr_ff <= 8'h00;
         upd_ff <= UPD_NONE;
      end else if (phase_ff == Q4) begin
         // The second table read cycle follows the first; no new decode.
         trd2_ff <= trd1_ff; // [RULE10]
         trd1_ff <= 1'b0;
         swap_ff <= 1'b0;
      end else if (phase_ff == Q1 && !trd2_ff && instr_valid) begin
         swap_ff <= is_swap;
         trd1_ff <= is_trd;
         dest_ff <= instr_word[DEST_BIT];
         bank_ff <= instr_word[BANK_BIT];
         faddr_ff <= instr_word[7:0];
         upd_ff <= instr_word[1:0];
      end
   end

   // Bank bit 0 maps the address into the fast bank: low half to bank 0,
   // high half to bank 15, which is the usual split of a shared bank.
   always_comb begin
      if (bank_ff) begin
         reg_addr = {bank_select_register, faddr_ff}; // [RULE4]
      end else if (faddr_ff[7]) begin
         reg_addr = {4'hf, faddr_ff}; // [RULE4]
      end else begin
         reg_addr = {4'h0, faddr_ff}; // [RULE4]
      end
   end

   assign reg_rd = swap_ff && phase_ff == Q2; // [RULE11]
   assign reg_we = swap_ff && dest_ff && phase_ff == Q4; // [RULE3]
   assign work_reg_we = swap_ff && !dest_ff && phase_ff == Q4; // [RULE3]
   assign reg_wdata = swapped_ff;
   assign work_reg_wdata = swapped_ff;
   assign status_we = 1'b0; // [RULE2] [RULE9]

   // Swap data path: capture in Q2, swap in Q3.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_ff <= 8'h00;
         swapped_ff <= 8'h00;
      end else begin
         if (reg_rd) begin
            data_ff <= reg_rdata;
         end
         if (swap_ff && phase_ff == Q3) begin
            swapped_ff <= {data_ff[3:0], data_ff[7:4]}; // [RULE2]
         end
      end
   end

   // Pointer update at Q4 of the first cycle; pre-increment reads new value.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_ff <= PTR_WIDTH'(PTR_RESET);
         rd_ptr_ff <= PTR_WIDTH'(PTR_RESET);
      end else if (trd1_ff && phase_ff == Q4) begin
         case (upd_ff)
            UPD_NONE: begin
               rd_ptr_ff <= ptr_ff; // [RULE6]
            end
            UPD_POST_INC: begin
               rd_ptr_ff <= ptr_ff;
               ptr_ff <= ptr_ff + one_p; // [RULE6] [RULE7]
            end
            UPD_POST_DEC: begin
               rd_ptr_ff <= ptr_ff;
               ptr_ff <= ptr_ff - one_p; // [RULE6] [RULE7]
            end
            default: begin
               rd_ptr_ff <= ptr_ff + one_p; // [RULE6] [RULE7]
               ptr_ff <= ptr_ff + one_p;
            end
         endcase
      end
   end

   assign pm_rd = trd2_ff && phase_ff == Q2; // [RULE10]
   assign pm_addr = rd_ptr_ff[PTR_WIDTH-1:1];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pm_byte_ff <= LATCH_RESET;
         latch_ff <= LATCH_RESET;
      end else begin
         if (pm_rd) begin
            if (rd_ptr_ff[0]) begin
               pm_byte_ff <= pm_rdata[15:8]; // [RULE8]
            end else begin
               pm_byte_ff <= pm_rdata[7:0]; // [RULE8]
            end
         end
         if (trd2_ff && phase_ff == Q4) begin
            latch_ff <= pm_byte_ff; // [RULE9] [RULE10]
         end
      end
   end

   assign busy = trd1_ff || trd2_ff;
   assign phase = phase_ff;
   assign table_pointer = ptr_ff;
   assign table_latch = latch_ff;

   swap_result_a: assert property ( // [RULE2]
      @(posedge clk) disable iff (!reset_n)
      (swap_ff && phase_ff == Q3) |=>
      swapped_ff == {$past(data_ff[3:0]), $past(data_ff[7:4])})
      else $error("swap result wrong");
   swap_dest_a: assert property ( // [RULE3]
      @(posedge clk) disable iff (!reset_n)
      (reg_we || work_reg_we) |->
      (reg_we == dest_ff) && phase_ff == Q4)
      else $error("swap destination wrong");
   no_flags_a: assert property ( // [RULE9]
      @(posedge clk) disable iff (!reset_n)
      !status_we)
      else $error("status written");
   trd_latch_a: assert property ( // [RULE10]
      @(posedge clk) disable iff (!reset_n)
      pm_rd |-> ##2 (trd2_ff && phase_ff == Q4) ##1
      latch_ff == $past(pm_byte_ff))
      else $error("latch not loaded");
   trd_seq_a: assert property ( // [RULE10]
      @(posedge clk) disable iff (!reset_n)
      (trd1_ff && phase_ff == Q4) |=> trd2_ff [*4])
      else $error("second cycle missing");
   // A word offered while the second read cycle runs must not be decoded.
   trd_refuse_a: assert property ( // [RULE10]
      @(posedge clk) disable iff (!reset_n)
      (trd2_ff && phase_ff == Q1) |=> !swap_ff && !trd1_ff)
      else $error("word decoded in second cycle");
   ptr_none_a: assert property ( // [RULE6]
      @(posedge clk) disable iff (!reset_n)
      (trd1_ff && phase_ff == Q4 && upd_ff == UPD_NONE) |=>
      ptr_ff == $past(ptr_ff) && rd_ptr_ff == $past(ptr_ff))
      else $error("pointer changed without update");
   ptr_inc_a: assert property ( // [RULE6]
      @(posedge clk) disable iff (!reset_n)
      (trd1_ff && phase_ff == Q4 && upd_ff == UPD_POST_INC) |=>
      ptr_ff == $past(ptr_ff) + one_p && rd_ptr_ff == $past(ptr_ff))
      else $error("post increment wrong");
   ptr_dec_a: assert property ( // [RULE7]
      @(posedge clk) disable iff (!reset_n)
      (trd1_ff && phase_ff == Q4 && upd_ff == UPD_POST_DEC) |=>
      ptr_ff == $past(ptr_ff) - one_p && rd_ptr_ff == $past(ptr_ff))
      else $error("decrement wrong");
   ptr_pre_a: assert property ( // [RULE6]
      @(posedge clk) disable iff (!reset_n)
      (trd1_ff && phase_ff == Q4 && upd_ff == UPD_PRE_INC) |=>
      rd_ptr_ff == ptr_ff && ptr_ff == $past(ptr_ff) + one_p)
      else $error("pre increment wrong");
   ptr_hold_a: assert property ( // [RULE7]
      @(posedge clk) disable iff (!reset_n)
      !(trd1_ff && phase_ff == Q4) |=> $stable(ptr_ff))
      else $error("pointer moved outside update");
   latch_hold_a: assert property ( // [RULE9]
      @(posedge clk) disable iff (!reset_n)
      !(trd2_ff && phase_ff == Q4) |=> $stable(latch_ff))
      else $error("latch moved outside read");
   bank_fast_a: assert property ( // [RULE4]
      @(posedge clk) disable iff (!reset_n)
      (swap_ff && !bank_ff) |-> reg_addr[11:8] == {4{faddr_ff[7]}})
      else $error("fast bank wrong");
   swap_read_a: assert property ( // [RULE11]
      @(posedge clk) disable iff (!reset_n)
      reg_rd |-> ##2 (reg_we || work_reg_we))
      else $error("swap timing");
   swap_idle_a: assert property ( // [RULE11]
      @(posedge clk) disable iff (!reset_n)
      swap_ff |-> !busy)
      else $error("swap marked busy");
endmodule // nibble_swap_table_read_exec
`default_nettype wire

// file: test/pm_regfile_model.sv
// Behavioural program memory and data register file facing the unit.
`timescale 1ns/1ps
`default_nettype none
module pm_regfile_model (
   input wire logic [19:0] pm_addr,
   input wire logic pm_rd,
   output logic [15:0] pm_rdata,
   input wire logic [11:0] reg_addr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   // Outside a read the buses carry inverted contents, so a design that
   // samples at the wrong moment sees wrong data instead of a lucky match.
   always_comb begin
      pm_rdata = {pm_addr[7:0] ^ 8'h3C, pm_addr[7:0] ^ 8'hC3};
      reg_rdata = reg_addr[7:0] ^ {reg_addr[11:8], 4'h9};
      if (!pm_rd) pm_rdata = ~pm_rdata;
      if (!reg_rd) reg_rdata = ~reg_rdata;
   end
endmodule // pm_regfile_model
`default_nettype wire

// file: test/nibble_swap_table_read_exec_tb_top.sv
// Self-checking bench for the nibble swap and table read unit.
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_table_read_exec_tb_top;
   import swap_table_read_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [3:0] bank_select_register = 4'h6;
   logic [7:0] working_register = 8'h11;
   logic [7:0] reg_rdata, reg_wdata, work_reg_wdata, table_latch;
   logic [15:0] pm_rdata;
   logic [1:0] phase;
   logic [11:0] reg_addr;
   logic [19:0] pm_addr;
   logic [20:0] table_pointer;
   logic busy, reg_rd, reg_we, work_reg_we, pm_rd, status_we;
   logic [20:0] ptr = PTR_RESET;
   int n_errors = 0;
   int cmp_count = 0;
   nibble_swap_table_read_exec #(.PTR_WIDTH(21)) i_dut (.clk(clk),
      .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
      .bank_select_register(bank_select_register), .busy(busy),
      .working_register(working_register), .reg_rdata(reg_rdata),
      .pm_rdata(pm_rdata), .phase(phase), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_we(reg_we), .reg_wdata(reg_wdata),
      .work_reg_we(work_reg_we), .work_reg_wdata(work_reg_wdata),
      .pm_addr(pm_addr),
      .pm_rd(pm_rd), .table_pointer(table_pointer),
      .table_latch(table_latch), .status_we(status_we));
   pm_regfile_model i_mem (.pm_addr(pm_addr), .pm_rd(pm_rd),
      .pm_rdata(pm_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   task automatic give_verdict();
      $display("compares %0d, errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Presents a word in the decode phase and leaves right after decode.
   task automatic issue(input logic [15:0] w);
      int i;
      for (i = 0; i < 8 && phase !== 2'b00; i++) step(1);
      if (phase !== 2'b00) begin
         chk(1'b0, "decode phase never came");
         give_verdict();
      end else begin
         instr_valid = 1'b1;
         instr_word = w;
         step(1);
         instr_valid = 1'b0;
      end
   endtask
   task automatic test_swap(input logic d, input logic a, input logic [7:0] f);
      logic [11:0] ea;
      logic [7:0] v;
      ea = a ? {bank_select_register, f} : {(f < 8'h80) ? 4'h0 : 4'hF, f};
      v = ea[7:0] ^ {ea[11:8], 4'h9};
      v = {v[3:0], v[7:4]};
      issue({SWAP_OPC, d, a, f});
      chk(reg_rd === 1'b1 && reg_addr === ea, "swap read address");
      chk(busy === 1'b0, "swap held busy");
      step(2);
      chk(reg_we === d && work_reg_we === !d, "swap destination");
      chk((d ? reg_wdata : work_reg_wdata) === v, "swap");
      chk(status_we === 1'b0, "swap touched flags");
      $display("swap test done d=%0d a=%0d", d, a);
   endtask
   task automatic test_trd(input logic [1:0] c);
      logic [20:0] ra, np;
      logic [15:0] wd;
      ra = (c == UPD_PRE_INC) ? ptr + PTR_ONE : ptr;
      np = (c == UPD_POST_INC) ? ptr + PTR_ONE : ra;
      if (c == UPD_POST_DEC) np = ptr - PTR_ONE;
      wd = {ra[8:1] ^ 8'h3C, ra[8:1] ^ 8'hC3};
      issue({TRD_OPC, c});
      step(3);
      // A word offered in the second cycle's decode phase must be ignored.
      instr_valid = 1'b1;
      instr_word = {SWAP_OPC, 2'b10, 8'h20};
      step(1);
      instr_valid = 1'b0;
      chk(pm_rd === 1'b1 && busy === 1'b1, "fetch timing");
      chk(pm_addr === ra[20:1], "fetch address");
      chk(reg_rd === 1'b0, "word taken in second cycle");
      step(3);
      chk(table_latch === (ra[0] ? wd[15:8] : wd[7:0]), "latch");
      chk(table_pointer === np, "pointer update");
      chk(status_we === 1'b0, "read touched flags");
      ptr = np;
      $display("table read test done code=%0d", c);
   endtask
   // A word outside both encodings is dropped; a reset mid-read aborts it.
   task automatic test_reset();
      issue(16'h3000);
      chk(reg_rd === 1'b0 && busy === 1'b0, "foreign word taken");
      issue({TRD_OPC, UPD_POST_INC});
      step(2);
      reset_n = 1'b0;
      #1;
      chk(busy === 1'b0 && phase === 2'b00, "reset state");
      chk(table_pointer === PTR_RESET, "reset pointer");
      chk(table_latch === LATCH_RESET, "reset latch");
      step(2);
      reset_n = 1'b1;
      ptr = PTR_RESET;
      $display("reset test done");
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      test_swap(1'b1, 1'b0, 8'h53);
      test_swap(1'b0, 1'b0, 8'h85);
      test_swap(1'b1, 1'b1, 8'h7F);
      test_swap(1'b0, 1'b1, 8'hC2);
      test_trd(UPD_POST_DEC);
      test_trd(UPD_PRE_INC);
      test_trd(UPD_POST_INC);
      test_trd(UPD_NONE);
      test_trd(UPD_PRE_INC);
      test_reset();
      test_trd(UPD_POST_INC);
      give_verdict();
   end
endmodule // nibble_swap_table_read_exec_tb_top
`default_nettype wire
